// ==== hw/tasc_serial_if.sv ====
// serial control and result interface of the touch screen converter
`timescale 1ns/1ps
`default_nettype none
module tasc_serial_if
	import tasc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// serial pins
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output var logic serial_out,
	output var logic serial_out_oe,
	output var logic busy_out,
	output var logic busy_oe,
	// analog converter core
	output var tasc_conv_req_t conv_req,
	input wire logic result_valid,
	input wire logic [RESULT_W-1:0] result_data,
	output var logic result_ready,
	// power and panel status
	output var logic adc_power_on,
	output var logic ref_power_on,
	output var logic panel_drive_on
);
	localparam int DO_CYC = T_DO_CYC;
	localparam int BD_CYC = T_BD_CYC;

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic [2:0] pins_s;
	logic sclk_s;
	logic cs_s_n;
	logic sdi_s;
	logic sclk_prev_reg;
	logic rise;
	logic fall;
	logic cs_low;

	// select enters inverted so the zero reset of the sync means deselected
	tasc_sync #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in({serial_clock, !chip_select_n, serial_in}),
		.sync_out(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_low = pins_s[1];
	assign sdi_s = pins_s[0];
	assign cs_s_n = !cs_low;
	// edges count only while selected
	assign rise = cs_low && sclk_s && !sclk_prev_reg;
	assign fall = cs_low && !sclk_s && sclk_prev_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end

	// ****************************************
	// result buffer
	// ****************************************
	logic buf_valid;
	logic buf_ready;
	logic [RESULT_W-1:0] buf_data;

	tasc_pair_fifo #(.WIDTH(RESULT_W), .DEPTH(BUF_DEPTH)) u_buf (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(result_valid),
		.in_data(result_data),
		.in_ready(result_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_ready)
	);

	// ****************************************
	// control byte receiver
	// ****************************************
	logic parse_active_reg;
	logic [2:0] parse_cnt_reg;
	logic [6:0] parse_shift_reg;
	tasc_ctrl_t ctrl_reg;
	logic pending_reg;
	logic acq_reg;
	tasc_conv_state_t state_reg;
	logic byte_done;

	assign byte_done = rise && parse_active_reg &&
		(parse_cnt_reg == CTRL_LAST_IDX);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			parse_active_reg <= 1'b0;
			parse_cnt_reg <= 3'h0;
			parse_shift_reg <= 7'h00;
		end else if (cs_s_n) begin
			parse_active_reg <= 1'b0;
			parse_cnt_reg <= 3'h0;
		end else if (rise) begin
			if (!parse_active_reg) begin
				// wait for a high start bit
				if (sdi_s) begin
					parse_active_reg <= 1'b1;
					parse_cnt_reg <= 3'h1;
					parse_shift_reg <= 7'h01;
				end
			end else begin
				parse_shift_reg <= {parse_shift_reg[5:0], sdi_s};
				parse_cnt_reg <= parse_cnt_reg + 3'h1;
				if (parse_cnt_reg == CTRL_LAST_IDX) begin
					parse_active_reg <= 1'b0;
				end
			end
		end
	end

	// byte layout follows the packed struct field order
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= tasc_ctrl_t'(CTRL_RESET);
		end else if (byte_done) begin
			ctrl_reg <= tasc_ctrl_t'({parse_shift_reg, sdi_s});
		end
	end

	// a byte may land while a result is still shifting out
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pending_reg <= 1'b0;
		end else if (cs_s_n) begin
			pending_reg <= 1'b0;
		end else if (byte_done) begin
			pending_reg <= 1'b1;
		end else if (fall && pending_reg) begin
			pending_reg <= 1'b0;
		end
	end

	// acquisition runs from the A0 channel bit, the last of the three, to busy
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			acq_reg <= 1'b0;
		end else if (cs_s_n) begin
			acq_reg <= 1'b0;
		end else if (rise && parse_active_reg &&
			parse_cnt_reg == CTRL_A0_IDX) begin
			acq_reg <= 1'b1;
		end else if (fall && pending_reg) begin
			acq_reg <= 1'b0;
		end
	end

	// ****************************************
	// conversion and result shifter
	// ****************************************
	logic [RESULT_W-1:0] hold_reg;
	logic have_word_reg;
	logic [RESULT_W-1:0] shift_reg;
	logic [3:0] bits_left_reg;
	logic [RESULT_W-1:0] load_word;

	// stale words from abandoned conversions are drained whenever not in CV_BUSY
	assign buf_ready = (state_reg != CV_BUSY) || !have_word_reg;
	// reduced resolution keeps the top bits, msb aligned
	assign load_word = ctrl_reg.res_8bit ?
		{hold_reg[RESULT_W-1:RED_LSB], {RED_LSB{1'b0}}} : hold_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hold_reg <= '0;
			have_word_reg <= 1'b0;
		end else if (state_reg == CV_BUSY) begin
			if (buf_valid && !have_word_reg) begin
				hold_reg <= buf_data;
				have_word_reg <= 1'b1;
			end
		end else begin
			have_word_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= CV_IDLE;
			shift_reg <= '0;
			bits_left_reg <= 4'h0;
			busy_out <= 1'b0;
			serial_out <= 1'b0;
		end else if (cs_s_n) begin
			state_reg <= CV_IDLE;
			busy_out <= 1'b0;
			serial_out <= 1'b0;
		end else if (fall) begin
			if (pending_reg) begin
				// new byte cuts short any result still going out
				state_reg <= CV_BUSY;
				busy_out <= 1'b1;
				serial_out <= 1'b0;
			end else begin
				unique case (state_reg)
					CV_IDLE: begin
						serial_out <= 1'b0;
					end
					CV_BUSY: begin
						busy_out <= 1'b0;
						state_reg <= CV_SHIFT;
						shift_reg <= {load_word[RESULT_W-2:0], 1'b0};
						serial_out <= load_word[RESULT_W-1];
						bits_left_reg <= ctrl_reg.res_8bit ?
							BITS_RED_LAST : BITS_FULL_LAST;
					end
					CV_SHIFT: begin
						if (bits_left_reg == 4'h0) begin
							state_reg <= CV_IDLE;
							serial_out <= 1'b0;
						end else begin
							serial_out <= shift_reg[RESULT_W-1];
							shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
							bits_left_reg <= bits_left_reg - 4'h1;
						end
					end
					default: begin
						state_reg <= CV_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// output enables and analog requests
	// ****************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			serial_out_oe <= 1'b0;
			busy_oe <= 1'b0;
		end else begin
			busy_oe <= cs_low;
			if (cs_s_n) begin
				serial_out_oe <= 1'b0;
			end else if (!busy_oe) begin
				serial_out_oe <= 1'b1;
			end else if (fall && pending_reg) begin
				serial_out_oe <= 1'b1;
			end else if (fall && state_reg == CV_SHIFT &&
				bits_left_reg == 4'h0) begin
				serial_out_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			conv_req <= '0;
		end else begin
			conv_req.valid <= fall && pending_reg;
			conv_req.channel_sel <= ctrl_reg.channel_sel;
			conv_req.res_8bit <= ctrl_reg.res_8bit;
			conv_req.ref_mode_sel <= ctrl_reg.ref_mode_sel;
		end
	end

	// ****************************************
	// power and panel drivers
	// ****************************************
	logic converting;

	assign converting = pending_reg || acq_reg || (state_reg != CV_IDLE);

	// reference power is latched only as busy rises, never by chip select
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ref_power_on <= REF_POWER_RESET;
		end else if (fall && pending_reg) begin
			ref_power_on <= ctrl_reg.reference_power_sel;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			adc_power_on <= 1'b0;
			panel_drive_on <= 1'b0;
		end else begin
			adc_power_on <= cs_low &&
				(ctrl_reg.auto_powerdown_sel || converting);
			panel_drive_on <= cs_low && (acq_reg ||
				(!ctrl_reg.ref_mode_sel && state_reg != CV_IDLE));
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_capture;
		(rise && parse_active_reg && parse_cnt_reg != CTRL_LAST_IDX) |=>
			parse_shift_reg[0] == $past(sdi_s);
	endproperty
	a_capture: assert property (p_capture)
		else $error("input bit not captured on rising edge");

	property p_out_on_fall;
		$changed(serial_out) |-> $past(fall) || $past(cs_s_n);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("serial output changed without falling edge");

	property p_out_release;
		cs_s_n |=> !serial_out_oe;
	endproperty
	a_out_release: assert property (p_out_release)
		else $error("serial output driven while deselected");

	property p_busy_oe;
		cs_s_n |=> !busy_oe ##1 (!busy_oe || !$past(cs_s_n));
	endproperty
	a_busy_oe: assert property (p_busy_oe)
		else $error("busy enable not released with chip select");

	property p_busy_rise;
		(fall && pending_reg) |-> ##[1:BD_CYC] busy_out;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy did not rise at conversion start");

	property p_ignore_deselect;
		cs_s_n |=> state_reg == CV_IDLE && !parse_active_reg && !busy_out;
	endproperty
	a_ignore_deselect: assert property (p_ignore_deselect)
		else $error("activity while chip select high");

	property p_length;
		(fall && !pending_reg && state_reg == CV_BUSY) |=>
			bits_left_reg == (ctrl_reg.res_8bit ? 4'h7 : 4'hb);
	endproperty
	a_length: assert property (p_length)
		else $error("wrong result length loaded");

	property p_msb_first;
		(fall && !pending_reg && state_reg == CV_BUSY) |=>
			serial_out == $past(load_word[RESULT_W-1]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("result msb not first");

	property p_full_power;
		(cs_low && ctrl_reg.auto_powerdown_sel) |=> adc_power_on;
	endproperty
	a_full_power: assert property (p_full_power)
		else $error("converter powered down with power bit set");

	property p_single_ended;
		(ctrl_reg.ref_mode_sel && !acq_reg) |=> !panel_drive_on;
	endproperty
	a_single_ended: assert property (p_single_ended)
		else $error("panel driven outside acquisition");

	property p_cs_powerdown;
		cs_s_n |=> !adc_power_on ##1 !adc_power_on || !$past(cs_s_n);
	endproperty
	a_cs_powerdown: assert property (p_cs_powerdown)
		else $error("converter not powered down on deselect");

	property p_ref_hold;
		$changed(ref_power_on) |-> $rose(busy_out);
	endproperty
	a_ref_hold: assert property (p_ref_hold)
		else $error("reference power changed outside busy rise");

	property p_start_bit;
		(!parse_active_reg && rise && !sdi_s) |=> !parse_active_reg;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("byte started without start bit");

	c_full: cover property ((fall && state_reg == CV_SHIFT &&
		bits_left_reg == 4'h0 && !ctrl_reg.res_8bit));
	c_reduced: cover property ((fall && state_reg == CV_SHIFT &&
		bits_left_reg == 4'h0 && ctrl_reg.res_8bit));
	c_overlap: cover property ((byte_done && state_reg == CV_SHIFT));
	c_abort: cover property ((cs_s_n && $past(state_reg) == CV_SHIFT));

endmodule : tasc_serial_if
`default_nettype wire

// ==== shared/tasc_pkg.sv ====
// constants, types and states of the touch converter serial interface
package tasc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int SYS_CLK_MHZ = 40;
	localparam int T_DO_MAX_NS = 200;
	localparam int T_BD_MAX_NS = 200;
	localparam int T_DO_CYC = (T_DO_MAX_NS * SYS_CLK_MHZ) / 1000;
	localparam int T_BD_CYC = (T_BD_MAX_NS * SYS_CLK_MHZ) / 1000;

	// ****************************************
	// framing and widths
	// ****************************************
	localparam int RESULT_W = 12;
	localparam int BUF_DEPTH = 2;
	localparam logic [2:0] CTRL_LAST_IDX = 3'h7;
	localparam logic [2:0] CTRL_A0_IDX = 3'h3;
	localparam logic [3:0] BITS_FULL_LAST = 4'hb;
	localparam logic [3:0] BITS_RED_LAST = 4'h7;
	localparam int RED_LSB = 4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic REF_POWER_RESET = 1'b0;

	// control byte, msb first on the wire
	typedef struct packed {
		logic start;
		logic [2:0] channel_sel;
		logic res_8bit;
		logic ref_mode_sel;
		logic reference_power_sel;
		logic auto_powerdown_sel;
	} tasc_ctrl_t;

	// request to the analog converter core
	typedef struct packed {
		logic valid;
		logic [2:0] channel_sel;
		logic res_8bit;
		logic ref_mode_sel;
	} tasc_conv_req_t;

	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_BUSY = 2'b01,
		CV_SHIFT = 2'b10
	} tasc_conv_state_t;

endpackage : tasc_pkg

// ==== hw/tasc_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tasc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] async_in,
	output var logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule : tasc_sync
`default_nettype wire

// ==== hw/tasc_pair_fifo.sv ====
// small fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tasc_pair_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output var logic in_ready,
	// drain side
	output var logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic [PW:0] count_next;
	logic do_wr;
	logic do_rd;

	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (do_wr && !do_rd) begin
			count_next = count_reg + (PW + 1)'(1);
		end else if (do_rd && !do_wr) begin
			count_next = count_reg - (PW + 1)'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 :
					wr_ptr_reg + PW'(1);
			end
			if (do_rd) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 :
					rd_ptr_reg + PW'(1);
			end
			count_reg <= count_next;
			in_ready <= (count_next != FULL_CNT);
			out_valid <= (count_next != '0);
		end
	end
endmodule : tasc_pair_fifo
`default_nettype wire

// ==== verification/tasc_host_model.sv ====
// host-side model that drives the serial pins and records what comes back
`timescale 1ns/1ps
`default_nettype none
module tasc_host_model (
	// clock
	input wire logic sys_clk,
	// pins to the device
	output var logic serial_clock,
	output var logic chip_select_n,
	output var logic serial_in,
	// pins and status from the device
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic busy_out,
	input wire logic [1:0] probe_in
);
	// half period kept above the 8-cycle minimum of each clock phase
	localparam int HALF = 10;
	logic [63:0] smp_dout;
	logic [63:0] smp_busy;
	logic [63:0] smp_oe;
	logic [63:0] smp_power;
	logic [63:0] smp_panel;

	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end

	// select is set to the given level, then held for HALF cycles before returning
	task automatic chip_sel(input logic level);
		@(posedge sys_clk);
		chip_select_n <= level;
		repeat (HALF) @(posedge sys_clk);
	endtask : chip_sel

	// ****
	// one serial clock per bit, msb first; sample k is seen before rise k
	// ****
	task automatic clocks(input logic [63:0] din, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge sys_clk);
			serial_in <= din[63-k];
			repeat (HALF - 1) @(posedge sys_clk);
			@(negedge sys_clk);
			smp_dout[k+1] = serial_out;
			smp_busy[k+1] = busy_out;
			smp_oe[k+1] = serial_out_oe;
			smp_power[k+1] = probe_in[1];
			smp_panel[k+1] = probe_in[0];
			@(posedge sys_clk);
			serial_clock <= 1'b1;
			repeat (HALF) @(posedge sys_clk);
			serial_clock <= 1'b0;
		end
	endtask : clocks
endmodule : tasc_host_model
`default_nettype wire

// ==== verification/tasc_serial_if_tb_top.sv ====
// self-checking testbench of the touch converter serial interface
`timescale 1ns/1ps
`default_nettype none
module tasc_serial_if_tb_top
	import tasc_pkg::*;
();
	logic sys_clk;
	logic reset;
	logic serial_clock;
	logic chip_select_n;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic busy_out;
	logic busy_oe;
	tasc_conv_req_t conv_req;
	logic result_valid;
	logic [RESULT_W-1:0] result_data;
	logic result_ready;
	logic adc_power_on;
	logic ref_power_on;
	logic panel_drive_on;
	int fail_count;
	int tests_run;
	int req_count;
	int word_idx;
	tasc_conv_req_t last_req;
	logic [11:0] words [0:7];

	tasc_serial_if i_dut (.sys_clk(sys_clk), .reset(reset),
		.serial_clock(serial_clock), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .busy_out(busy_out),
		.busy_oe(busy_oe), .conv_req(conv_req),
		.result_valid(result_valid), .result_data(result_data),
		.result_ready(result_ready), .adc_power_on(adc_power_on),
		.ref_power_on(ref_power_on), .panel_drive_on(panel_drive_on));

	tasc_host_model i_host (.sys_clk(sys_clk), .serial_clock(serial_clock),
		.chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.busy_out(busy_out), .probe_in({adc_power_on, panel_drive_on}));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ****
	// analog core stand-in: one word per request, held until taken
	// ****
	always @(posedge sys_clk) begin
		if (conv_req.valid) begin
			req_count <= req_count + 1;
			last_req <= conv_req;
			result_valid <= 1'b1;
			result_data <= words[word_idx[2:0]];
			word_idx <= word_idx + 1;
		end else if (result_valid && result_ready) begin
			result_valid <= 1'b0;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [11:0] take(input logic [63:0] v,
		input int first, input int n);
		logic [11:0] r;
		r = 12'h000;
		for (int i = 0; i < n; i++) r = {r[10:0], v[first+i]};
		return r;
	endfunction : take

	task automatic t_reset();
		chk({serial_out_oe, busy_oe, adc_power_on, ref_power_on}, 0);
		chk(result_ready, 1);
		$display("t_reset done");
	endtask : t_reset

	// two idle zeros before the start bit, single-ended, auto power-down
	task automatic t_conv12_single();
		int r0;
		r0 = req_count;
		i_host.chip_sel(1'b0);
		i_host.clocks({2'b00, 8'hd6, 54'h0}, 26);
		chk(req_count - r0, 1);
		chk({last_req.channel_sel, last_req.res_8bit, last_req.ref_mode_sel},
			5'h15);
		chk(i_host.smp_busy[11], 1);
		chk(i_host.smp_busy[12], 0);
		chk(take(i_host.smp_dout, 12, 12), 12'ha5c);
		chk(i_host.smp_oe[10], 1);
		chk(i_host.smp_oe[24], 0);
		chk(i_host.smp_panel[10], 1);
		chk(i_host.smp_panel[13], 0);
		chk(i_host.smp_power[13], 1);
		chk(i_host.smp_power[26], 0);
		i_host.chip_sel(1'b1);
		chk({serial_out_oe, busy_oe, adc_power_on, ref_power_on}, 1);
		$display("t_conv12_single done");
	endtask : t_conv12_single

	// reduced resolution, differential reference, always powered
	task automatic t_conv8_diff();
		i_host.chip_sel(1'b0);
		i_host.clocks({8'ha9, 56'h0}, 24);
		chk(last_req.res_8bit, 1);
		chk(take(i_host.smp_dout, 10, 8), 8'h3c);
		chk(i_host.smp_oe[17], 1);
		chk(i_host.smp_oe[18], 0);
		chk(i_host.smp_panel[11], 1);
		chk(i_host.smp_power[24], 1);
		i_host.chip_sel(1'b1);
		chk({adc_power_on, ref_power_on, busy_oe}, 0);
		$display("t_conv8_diff done");
	endtask : t_conv8_diff

	// next byte starts on clock 16 while the first result still shifts
	task automatic t_overlap15();
		int r0;
		r0 = req_count;
		i_host.chip_sel(1'b0);
		i_host.clocks({8'h97, 7'h00, 8'hd3, 41'h0}, 38);
		chk(req_count - r0, 2);
		chk(i_host.smp_busy[9], 1);
		chk(take(i_host.smp_dout, 10, 12), 12'hf01);
		chk(i_host.smp_busy[24], 1);
		chk(take(i_host.smp_dout, 25, 12), 12'h0ff);
		chk(i_host.smp_oe[37], 0);
		i_host.chip_sel(1'b1);
		$display("t_overlap15 done");
	endtask : t_overlap15

	// select dropped mid-result, then clocks while deselected
	task automatic t_abort();
		int r0;
		i_host.chip_sel(1'b0);
		i_host.clocks({8'hd7, 56'h0}, 12);
		i_host.chip_sel(1'b1);
		chk({serial_out_oe, busy_oe, busy_out, adc_power_on}, 0);
		chk(ref_power_on, 1);
		r0 = req_count;
		i_host.clocks({64{1'b1}}, 10);
		chk(req_count - r0, 0);
		i_host.chip_sel(1'b0);
		i_host.clocks(64'h0, 12);
		chk(i_host.smp_busy[12:1], 0);
		chk(req_count - r0, 0);
		i_host.chip_sel(1'b1);
		$display("t_abort done");
	endtask : t_abort

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	// whole sequence needs about 2700 cycles; allow generous margin
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end

	initial begin
		reset = 1'b1;
		fail_count = 0;
		tests_run = 0;
		req_count = 0;
		word_idx = 0;
		last_req = '0;
		result_valid = 1'b0;
		result_data = 12'h000;
		words = '{12'ha5c, 12'h3c7, 12'hf01, 12'h0ff, 12'h123, 12'h000,
			12'h000, 12'h000};
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (6) @(posedge sys_clk);
		t_reset();
		t_conv12_single();
		t_conv8_diff();
		t_overlap15();
		t_abort();
		complete_run();
	end
endmodule : tasc_serial_if_tb_top
`default_nettype wire
